// ### verilog/sysbus_own_params.svh
// timing and encoding constants for the system bus ownership handshake
`ifndef SYSBUS_OWN_PARAMS_SVH
`define SYSBUS_OWN_PARAMS_SVH
`define SYSBUS_OWN_SYNC_STAGES 3
`define SYSBUS_OWN_RDCNT_W 4
`define SYSBUS_OWN_MODE_NATIVE 1'b1
`endif

// ### verilog/sysbus_own_pkg.sv
// types for the system bus ownership handshake
package sysbus_own_pkg;
  typedef enum logic [1:0] {
    OWN_MASTER = 2'b00,
    OWN_RELEASE = 2'b01,
    OWN_SLAVE = 2'b10
  } own_state_type;
endpackage

// ### verilog/sysbus_ownership_handshake.sv
// bus ownership handshake between the processor and the external agent
// ==========================================================
`timescale 1ns/10ps
`include "sysbus_own_params.svh"
module sysbus_ownership_handshake
  import sysbus_own_pkg::*;
#(
  parameter int RDCNT_W = `SYSBUS_OWN_RDCNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cold_reset_i,
  // pins from the external agent
  input wire logic protocol_select_strap_n_i,
  input wire logic ext_bus_request_n_i,
  input wire logic compat_ext_request_n_i,
  input wire logic ext_null_request_i,
  // processor core side
  input wire logic core_pending_i,
  input wire logic core_want_slave_i,
  input wire logic read_issue_i,
  input wire logic read_done_i,
  input wire logic protocol_error_i,
  // pins to the external agent
  output logic release_n_o,
  output logic proc_bus_owner_n_o,
  output logic proc_pending_request_n_o,
  output logic sys_addr_data_bus_oe_o,
  output logic native_mode_o
);
  // refuse a read counter that cannot hold even one outstanding read
  if (RDCNT_W < 1) begin : g_bad_width
    $error("RDCNT_W must be at least 1");
  end

  // ==========================================================
  // input synchronisers, three stages, change taken when last two agree
  logic [2:0] ext_sync_q, ext_sync_d, cmp_sync_q, cmp_sync_d, strap_sync_q, strap_sync_d;
  logic ext_req_q, ext_req_d, cmp_req_q, cmp_req_d;
  always_comb begin
    ext_sync_d = {ext_sync_q[1:0], ~ext_bus_request_n_i};
    cmp_sync_d = {cmp_sync_q[1:0], ~compat_ext_request_n_i};
    strap_sync_d = {strap_sync_q[1:0], protocol_select_strap_n_i};
    ext_req_d = (ext_sync_q[2] == ext_sync_q[1]) ? ext_sync_q[2] : ext_req_q;
    cmp_req_d = (cmp_sync_q[2] == cmp_sync_q[1]) ? cmp_sync_q[2] : cmp_req_q;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sync_q <= 3'h0;
      cmp_sync_q <= 3'h0;
      strap_sync_q <= 3'h7;
      ext_req_q <= 1'b0;
      cmp_req_q <= 1'b0;
    end else begin
      ext_sync_q <= ext_sync_d;
      cmp_sync_q <= cmp_sync_d;
      strap_sync_q <= strap_sync_d;
      ext_req_q <= ext_req_d;
      cmp_req_q <= cmp_req_d;
    end
  end

  // ==========================================================
  // protocol mode, captured while cold reset is held
  logic mode_q, mode_d;
  always_comb begin
    mode_d = mode_q;
    if (cold_reset_i && strap_sync_q[2] == strap_sync_q[1]) begin
      mode_d = strap_sync_q[2];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= `SYSBUS_OWN_MODE_NATIVE;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // outstanding read count
  logic [RDCNT_W-1:0] rd_cnt_q, rd_cnt_d;
  always_comb begin
    rd_cnt_d = rd_cnt_q;
    if (read_issue_i && !read_done_i && rd_cnt_q != {RDCNT_W{1'b1}}) begin
      rd_cnt_d = rd_cnt_q + RDCNT_W'(1);
    end else if (read_done_i && !read_issue_i && rd_cnt_q != '0) begin
      rd_cnt_d = rd_cnt_q - RDCNT_W'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_cnt_q <= '0;
    end else begin
      rd_cnt_q <= rd_cnt_d;
    end
  end

  // ==========================================================
  // ownership state machine
  own_state_type st_q, st_d;
  // active-low pins are kept active low in their flops, so no gate follows them
  logic rel_n_q, rel_n_d, own_n_q, own_n_d, proc_pending_request_n_n_q, proc_pending_request_n_n_d, oe_q, oe_d, tog_q, tog_d;
  logic ext_ask, uncompelled;
  always_comb begin
    ext_ask = mode_q ? ext_req_q : cmp_req_q;
    uncompelled = core_want_slave_i && (mode_q ? (rd_cnt_q != '0) : (rd_cnt_q == RDCNT_W'(1)));
    st_d = st_q;
    rel_n_d = 1'b1;
    case (st_q)
      OWN_MASTER: begin
        if (ext_ask || uncompelled) begin
          st_d = OWN_RELEASE;
          rel_n_d = !mode_q;
        end
      end
      OWN_RELEASE: begin
        st_d = OWN_SLAVE;
      end
      OWN_SLAVE: begin
        if (mode_q ? ext_null_request_i : !cmp_req_q) begin
          st_d = OWN_MASTER;
        end
      end
      default: begin
        st_d = OWN_MASTER;
      end
    endcase
    // the owner pin only means something in compat mode; native keeps it inactive
    own_n_d = mode_q || st_d != OWN_MASTER;
    oe_d = st_d == OWN_MASTER;
    tog_d = protocol_error_i ? ~tog_q : 1'b0;
    if (mode_q) begin
      proc_pending_request_n_n_d = !(core_pending_i && st_d != OWN_MASTER);
    end else if (protocol_error_i) begin
      proc_pending_request_n_n_d = !tog_q;
    end else begin
      proc_pending_request_n_n_d = !(core_pending_i && st_d != OWN_MASTER);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= OWN_MASTER;
      rel_n_q <= 1'b1;
      own_n_q <= 1'b1;
      proc_pending_request_n_n_q <= 1'b1;
      oe_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rel_n_q <= rel_n_d;
      own_n_q <= own_n_d;
      proc_pending_request_n_n_q <= proc_pending_request_n_n_d;
      oe_q <= oe_d;
      tog_q <= tog_d;
    end
  end

  // outputs straight from flip-flops
  assign release_n_o = rel_n_q;
  assign proc_bus_owner_n_o = own_n_q;
  assign proc_pending_request_n_o = proc_pending_request_n_n_q;
  assign sys_addr_data_bus_oe_o = oe_q;
  assign native_mode_o = mode_q;

  // ==========================================================
  // checks
  release_on_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q && st_q == OWN_MASTER && ext_req_q |=> !release_n_o)
    else $error("release not given after native request");
  release_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !release_n_o |=> release_n_o)
    else $error("release held longer than one cycle");
  owner_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_q && !mode_d && st_q == OWN_MASTER && cmp_req_q |=> proc_bus_owner_n_o)
    else $error("owner output not dropped on compat request");
  owner_slave_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == OWN_SLAVE |-> proc_bus_owner_n_o)
    else $error("owner output active while slave");
  toggle_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_q && protocol_error_i && $past(!mode_q && protocol_error_i) |=>
      proc_pending_request_n_o != $past(proc_pending_request_n_o))
    else $error("request output not toggling on error");
  pending_native_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q && core_pending_i && st_q == OWN_SLAVE && !ext_null_request_i
      |=> !proc_pending_request_n_o)
    else $error("pending request not shown");
  // the bus may only be driven while the state register says master
  one_driver_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q != OWN_MASTER |-> !sys_addr_data_bus_oe_o)
    else $error("bus driven while not master");
  mode_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cold_reset_i |=> $stable(native_mode_o))
    else $error("mode changed outside cold reset");
  // uncompelled changes to slave and the return of ownership
  uncompelled_rel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_q && st_q == OWN_MASTER && core_want_slave_i && rd_cnt_q != '0 |=> !release_n_o)
    else $error("no release on uncompelled slave change");
  uncompelled_own_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_q && st_q == OWN_MASTER && core_want_slave_i && rd_cnt_q == RDCNT_W'(1)
      |=> proc_bus_owner_n_o)
    else $error("owner output kept on uncompelled slave change");
  owner_back_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_q && st_q == OWN_SLAVE && !cmp_req_q |=> !proc_bus_owner_n_o)
    else $error("owner output not active after return to master");
  compat_request_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !mode_q && !protocol_error_i && core_pending_i && st_q == OWN_SLAVE && cmp_req_q
      |=> !proc_pending_request_n_o)
    else $error("compat ownership request not shown");
endmodule

// ### test/ext_agent_model.sv
// model of the external agent that borrows the system bus
`timescale 1ns/10ps
module ext_agent_model (
  // bench control
  input wire logic clk_i,
  input wire logic want_i,
  input wire logic give_back_i,
  // pins from the device
  input wire logic release_n_i,
  // pins to the device
  output logic ext_bus_request_n_o,
  output logic compat_ext_request_n_o,
  output logic ext_null_request_o
);
  logic got_q = 1'b0;
  logic null_q = 1'b0;
  // note the release, then hand the bus back with a null request
  always @(posedge clk_i) begin
    got_q <= want_i & (got_q | ~release_n_i);
    null_q <= give_back_i;
  end
  // the native request stops once the release was seen
  assign ext_bus_request_n_o = ~(want_i & ~got_q);
  assign compat_ext_request_n_o = ~want_i;
  assign ext_null_request_o = null_q;
endmodule

// ### test/sysbus_ownership_handshake_bench.sv
// self-checking bench for the bus ownership handshake
`timescale 1ns/10ps
module sysbus_ownership_handshake_bench;
  logic clk_i = 0, rst_i = 1, cold = 1, strap = 1, want = 0, back = 0;
  logic pend = 0, slv = 0, rdi = 0, rdd = 0, perr = 0, a;
  logic compat_ext_request_n_n, creq_n, enull, rel_n, own_n, proc_pending_request_n_n, oe, nat;
  int fail_count = 0, tests_run = 0, seed = 1, n;
  // ==========================================
  // clock, device and agent
  initial forever #25 clk_i = ~clk_i;
  sysbus_ownership_handshake dut (.clk_i(clk_i), .rst_i(rst_i), .cold_reset_i(cold),
    .protocol_select_strap_n_i(strap), .ext_bus_request_n_i(compat_ext_request_n_n),
    .compat_ext_request_n_i(creq_n), .ext_null_request_i(enull),
    .core_pending_i(pend), .core_want_slave_i(slv), .read_issue_i(rdi),
    .read_done_i(rdd), .protocol_error_i(perr), .release_n_o(rel_n),
    .proc_bus_owner_n_o(own_n), .proc_pending_request_n_o(proc_pending_request_n_n),
    .sys_addr_data_bus_oe_o(oe), .native_mode_o(nat));
  ext_agent_model agent (.clk_i(clk_i), .want_i(want), .give_back_i(back),
    .release_n_i(rel_n), .ext_bus_request_n_o(compat_ext_request_n_n),
    .compat_ext_request_n_o(creq_n), .ext_null_request_o(enull));
  // ==========================================
  // helpers
  function logic owner_exp(input logic native, input logic master);
    return native | ~master;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task boot(input logic s);
    @(posedge clk_i) rst_i <= 1;
    cold <= 1;
    strap <= s;
    slv <= 0;
    pend <= 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    // cold reset outlasts reset so the strap gets through its synchroniser
    repeat (6) @(posedge clk_i);
    cold <= 0;
    repeat (4) @(posedge clk_i);
    #1;
    chk(nat, s);
    chk(own_n, owner_exp(s, 1));
    chk(oe, 1);
  endtask
  // stop at the edge where the device gives up the bus
  task wait_grant(input logic native);
    for (n = 0; n < 12; n++) begin
      @(posedge clk_i) #1;
      if ((native ? rel_n : ~own_n) === 1'b0) break;
    end
  endtask
  task pulse_read(input logic done);
    @(posedge clk_i) rdi <= !done;
    rdd <= done;
    @(posedge clk_i) rdi <= 0;
    rdd <= 0;
  endtask
  // ==========================================
  // scenarios
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    complete_run;
  end
  initial begin
    boot(1);
    repeat ($unsigned($random(seed)) % 8) @(posedge clk_i);
    @(posedge clk_i) want <= 1;
    wait_grant(1);
    chk(n < 12, 1);
    chk(oe, 0);
    @(posedge clk_i) pend <= 1;
    want <= 0;
    #1 chk(rel_n, 1);
    repeat (3) @(posedge clk_i);
    #1 chk(proc_pending_request_n_n, 0);
    @(posedge clk_i) back <= 1;
    @(posedge clk_i) back <= 0;
    @(posedge clk_i) #1 chk(oe, 1);
    chk(proc_pending_request_n_n, 1);
    @(posedge clk_i) pend <= $random(seed);
    slv <= 1;
    wait_grant(1);
    chk(n, 12);
    @(posedge clk_i) slv <= 0;
    pulse_read(0);
    slv <= 1;
    wait_grant(1);
    chk(n < 12, 1);
    boot(0);
    @(posedge clk_i) want <= 1;
    pend <= 1;
    wait_grant(0);
    chk(n < 12, 1);
    chk(oe, 0);
    repeat (2) @(posedge clk_i);
    #1 chk(proc_pending_request_n_n, 0);
    @(posedge clk_i) perr <= 1;
    repeat (3) @(posedge clk_i);
    #1 a = proc_pending_request_n_n;
    @(posedge clk_i) #1 chk(proc_pending_request_n_n, !a);
    @(posedge clk_i) perr <= 0;
    want <= 0;
    pend <= 0;
    repeat (8) @(posedge clk_i);
    #1 chk(own_n, owner_exp(0, 1));
    pulse_read(0);
    pulse_read(0);
    slv <= 1;
    wait_grant(0);
    chk(n, 12);
    pulse_read(1);
    wait_grant(0);
    chk(n < 12, 1);
    complete_run;
  end
endmodule
